// [hw/pscd_decode.sv]
// pin strap decode with pmbus override of each parameter
//
// How it works
// - load strap parameters once at boot
// - override bit zero selects pin value
// - register variant ignores every strap pin
// - register variant boot voltage defaults zero
// - sixteen bins, short zero, float fifteen
// - frequency table per mode bin
// - frequencies 400 to 2000, never 1600
// - mode bin selects conduction mode too
// - unity scale boot voltage table
// - unity scale relative and fixed limits
// - half scale boot voltage table
// - half scale relative and fixed limits
`timescale 1ns/1ps
`default_nettype none
`include "pscd_params.svh"
module pscd_decode #(
  parameter int BIN_W = 4
) (
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  // variant and scale straps
  input wire logic i_reg_variant,
  input wire logic i_scale_half,
  // strap bins from the pin comparators, asynchronous
  input wire logic [3:0] i_mode_bin,
  input wire logic [3:0] i_boot_voltage_strap,
  // override mask register access
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // pmbus-written parameter values
  input wire logic [11:0] i_reg_freq_khz,
  input wire logic i_reg_diode_emulation,
  input wire logic [12:0] i_reg_vboot_mv,
  input wire logic [12:0] i_reg_fovp_mv,
  input wire logic [8:0] i_reg_rovp_mv,
  // applied configuration
  output logic o_loaded,
  output logic [11:0] o_freq_khz,
  output logic o_diode_emulation,
  output logic [12:0] o_vboot_mv,
  output logic [12:0] o_fovp_mv,
  output logic [8:0] o_rovp_mv
);
  // elaboration check: tables hold exactly sixteen bins
  if (BIN_W != 4)
  begin : g_bad_width
    $error("pscd_decode: BIN_W must be 4");
  end

  // two-flop synchronisers for the asynchronous strap inputs
  logic [9:0] sync1_q;
  logic [9:0] sync1_d;
  logic [9:0] sync2_q;
  logic [9:0] sync2_d;
  // sequencer and captured bins
  pscd_pkg::pscd_state_t st_q;
  pscd_pkg::pscd_state_t st_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [3:0] mbin_q;
  logic [3:0] mbin_d;
  logic [3:0] vbin_q;
  logic [3:0] vbin_d;
  logic half_q;
  logic half_d;
  logic regv_q;
  logic regv_d;
  // override mask
  logic [7:0] ovr_q;
  logic [7:0] ovr_d;
  // output registers
  logic [11:0] freq_q;
  logic [11:0] freq_d;
  logic dem_q;
  logic dem_d;
  logic [12:0] vb_q;
  logic [12:0] vb_d;
  logic [12:0] fo_q;
  logic [12:0] fo_d;
  logic [8:0] ro_q;
  logic [8:0] ro_d;
  // decoded table values
  logic [11:0] t_freq;
  logic t_dem;
  logic [12:0] t_vb;
  logic [12:0] t_fo;
  logic [8:0] t_ro;
  // per-parameter pin use: pin when variant straps and bit is clear
  logic use_f;
  logic use_m;
  logic use_v;
  logic use_fo;
  logic use_ro;

  // synchroniser next values; first stage feeds only the second
  always_comb
  begin
    sync1_d = {i_reg_variant, i_scale_half, i_mode_bin,
               i_boot_voltage_strap};
    sync2_d = sync1_q;
  end

  always_comb
  begin
    case (mbin_q)
      4'h0: t_freq = 12'd600;
      4'h1: t_freq = 12'd1000;
      4'h2: t_freq = 12'd1400;
      4'h3: t_freq = 12'd2000;
      4'h4: t_freq = 12'd1200;
      4'h5: t_freq = 12'd1400;
      4'h6: t_freq = 12'd1800;
      4'h7: t_freq = 12'd2000;
      4'h8: t_freq = 12'd400;
      4'h9: t_freq = 12'd600;
      4'ha: t_freq = 12'd800;
      4'hb: t_freq = 12'd1000;
      4'hc: t_freq = 12'd400;
      4'hd: t_freq = 12'd1800;
      4'he: t_freq = 12'd1200;
      default: t_freq = 12'd800;
    endcase
    // mode groups, diode emulation bins 4..11
    t_dem = (mbin_q >= 4'h4) && (mbin_q <= 4'hb);
  end

  // boot voltage and limit tables, millivolts
  always_comb
  begin
    if (!half_q)
    begin
      case (vbin_q)
        4'h0: t_vb = 13'd400;
        4'h1: t_vb = 13'd500;
        4'h2: t_vb = 13'd600;
        4'h3: t_vb = 13'd700;
        4'h4: t_vb = 13'd800;
        4'h5: t_vb = 13'd900;
        4'h6: t_vb = 13'd1000;
        4'h7: t_vb = 13'd1050;
        4'h8: t_vb = 13'd1100;
        4'h9: t_vb = 13'd1200;
        4'ha: t_vb = 13'd1250;
        4'hb: t_vb = 13'd1350;
        4'hc: t_vb = 13'd1500;
        4'hd: t_vb = 13'd1650;
        4'he: t_vb = 13'd1800;
        default: t_vb = 13'd2500;
      endcase
      case (vbin_q)
        4'h0: t_fo = 13'd800;
        4'h1, 4'h2: t_fo = 13'd1000;
        4'h3, 4'h4, 4'h5: t_fo = 13'd1200;
        4'h6, 4'h7, 4'h8: t_fo = 13'd1350;
        4'h9: t_fo = 13'd1500;
        4'ha, 4'hb: t_fo = 13'd1800;
        4'hc, 4'hd, 4'he: t_fo = 13'd2200;
        default: t_fo = 13'd2850;
      endcase
      if (vbin_q <= 4'h3)
        t_ro = 9'd150;
      else if (vbin_q <= 4'h9)
        t_ro = 9'd200;
      else if (vbin_q <= 4'hb)
        t_ro = 9'd250;
      else
        t_ro = 9'd300;
    end
    else
    begin
      case (vbin_q)
        4'h0: t_vb = 13'd800;
        4'h1: t_vb = 13'd1000;
        4'h2: t_vb = 13'd1200;
        4'h3: t_vb = 13'd1400;
        4'h4: t_vb = 13'd1600;
        4'h5: t_vb = 13'd1800;
        4'h6: t_vb = 13'd2000;
        4'h7: t_vb = 13'd2100;
        4'h8: t_vb = 13'd2200;
        4'h9: t_vb = 13'd2400;
        4'ha: t_vb = 13'd2500;
        4'hb: t_vb = 13'd2700;
        4'hc: t_vb = 13'd3000;
        4'hd: t_vb = 13'd3300;
        4'he: t_vb = 13'd3600;
        default: t_vb = 13'd5000;
      endcase
      case (vbin_q)
        4'h0, 4'h1, 4'h2: t_fo = 13'd1600;
        4'h3: t_fo = 13'd2000;
        4'h4, 4'h5: t_fo = 13'd2400;
        4'h6, 4'h7, 4'h8: t_fo = 13'd2700;
        4'h9, 4'ha: t_fo = 13'd3000;
        4'hb, 4'hc: t_fo = 13'd3600;
        4'hd, 4'he: t_fo = 13'd4400;
        default: t_fo = 13'd5700;
      endcase
      t_ro = (vbin_q <= 4'h2) ? 9'd200 : 9'd300;
    end
  end

  // pin or register selection per parameter
  always_comb
  begin
    // pin only when bit clear and variant straps
    use_f = !regv_q && !ovr_q[`PSCD_OVR_TON];
    use_m = !regv_q && !ovr_q[`PSCD_OVR_MODE];
    use_v = !regv_q && !ovr_q[`PSCD_OVR_VBOOT];
    use_fo = !regv_q && !ovr_q[`PSCD_OVR_FOVP];
    use_ro = !regv_q && !ovr_q[`PSCD_OVR_ROVP];
  end

  // sequencer, bin capture, override register and outputs
  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    mbin_d = mbin_q;
    vbin_d = vbin_q;
    half_d = half_q;
    regv_d = regv_q;
    ovr_d = ovr_q;
    freq_d = freq_q;
    dem_d = dem_q;
    vb_d = vb_q;
    fo_d = fo_q;
    ro_d = ro_q;
    // software write of the override mask
    if (i_reg_wr && (i_reg_addr == `PSCD_OVR_OFFSET))
      ovr_d = i_reg_wdata;
    case (st_q)
      // wait for synchronised straps to settle
      pscd_pkg::PSCD_IDLE:
      begin
        st_d = pscd_pkg::PSCD_SETTLE;
        cnt_d = `PSCD_LOAD_CYCLES;
      end
      pscd_pkg::PSCD_SETTLE:
      begin
        if (cnt_q == 4'h0)
        begin
          mbin_d = sync2_q[7:4];
          vbin_d = sync2_q[3:0];
          half_d = sync2_q[8];
          regv_d = sync2_q[9];
          st_d = pscd_pkg::PSCD_DONE;
        end
        else
          cnt_d = cnt_q - 4'h1;
      end
      pscd_pkg::PSCD_DONE:
      begin
        // override bit set takes register value
        freq_d = use_f ? t_freq : i_reg_freq_khz;
        dem_d = use_m ? t_dem : i_reg_diode_emulation;
        // register value defaults zero on that variant
        vb_d = use_v ? t_vb : i_reg_vboot_mv;
        fo_d = use_fo ? t_fo : i_reg_fovp_mv;
        ro_d = use_ro ? t_ro : i_reg_rovp_mv;
      end
      default:
        st_d = pscd_pkg::PSCD_IDLE;
    endcase
  end

  // state registers, frozen while enable is low
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      sync1_q <= 10'h000;
      sync2_q <= 10'h000;
      st_q <= pscd_pkg::PSCD_IDLE;
      cnt_q <= 4'h0;
      mbin_q <= 4'h0;
      vbin_q <= 4'h0;
      half_q <= 1'b0;
      regv_q <= 1'b0;
      ovr_q <= `PSCD_OVR_RESET;
      freq_q <= 12'h000;
      dem_q <= 1'b0;
      vb_q <= 13'h0000;
      fo_q <= 13'h0000;
      ro_q <= 9'h000;
    end
    else if (i_ce)
    begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      st_q <= st_d;
      cnt_q <= cnt_d;
      mbin_q <= mbin_d;
      vbin_q <= vbin_d;
      half_q <= half_d;
      regv_q <= regv_d;
      ovr_q <= ovr_d;
      freq_q <= freq_d;
      dem_q <= dem_d;
      vb_q <= vb_d;
      fo_q <= fo_d;
      ro_q <= ro_d;
    end
  end

  // read data: unmapped reads as zero
  always_comb
  begin
    o_reg_rdata = (i_reg_addr == `PSCD_OVR_OFFSET) ? ovr_q : 8'h00;
    o_loaded = (st_q == pscd_pkg::PSCD_DONE);
  end

  assign o_freq_khz = freq_q;
  assign o_diode_emulation = dem_q;
  assign o_vboot_mv = vb_q;
  assign o_fovp_mv = fo_q;
  assign o_rovp_mv = ro_q;
endmodule : pscd_decode
`default_nettype wire

// [hw/pscd_params.svh]
// constants for the pin strap configuration decoder
`ifndef PSCD_PARAMS_SVH
`define PSCD_PARAMS_SVH
// register offset of the strap override mask
`define PSCD_OVR_OFFSET 8'h5e
// override mask reset value: all parameters follow their pins unless the register variant is strapped
`define PSCD_OVR_RESET 8'h00
// override bit positions
`define PSCD_OVR_DOCP 0
`define PSCD_OVR_AOCP 1
`define PSCD_OVR_LCF 2
`define PSCD_OVR_VBOOT 3
`define PSCD_OVR_TON 4
`define PSCD_OVR_MODE 5
`define PSCD_OVR_FOVP 6
`define PSCD_OVR_ROVP 7
// boot load settle time in cycles
`define PSCD_LOAD_CYCLES 4'h4
`endif

// [hw/pscd_pkg.sv]
// types for the pin strap configuration decoder
`default_nettype none
package pscd_pkg;
  // load sequencer states, one-hot
  typedef enum logic [2:0] {
    PSCD_IDLE = 3'b001,
    PSCD_SETTLE = 3'b010,
    PSCD_DONE = 3'b100
  } pscd_state_t;
endpackage : pscd_pkg
`default_nettype wire

// [testbench/pscd_checker_properties.sv]
// assertion checker on the strap decoder ports
`timescale 1ns/1ps
`default_nettype none
module pscd_checker (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // register side
  input wire logic i_ce,
  input wire logic i_reg_variant,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic [11:0] i_reg_freq_khz,
  input wire logic [12:0] i_reg_vboot_mv,
  input wire logic [8:0] i_reg_rovp_mv,
  // applied values
  input wire logic o_loaded,
  input wire logic [11:0] o_freq_khz,
  input wire logic [12:0] o_vboot_mv,
  input wire logic [8:0] o_rovp_mv
);
  // cycles spent waiting for the boot load
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  // counts only while unloaded, so a hung loader shows up
  always_comb cnt_d = o_loaded ? 5'h00 : cnt_q + 5'h01;
  always_ff @(posedge i_clk or negedge i_nrst)
    if (!i_nrst)
      cnt_q <= 5'h00;
    else
      cnt_q <= cnt_d;
  default clocking dc @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  property p_rd_map;
    i_reg_addr != 8'h5e |-> o_reg_rdata == 8'h00;
  endproperty
  a_rd_map: assert property (p_rd_map)
    else $error("unmapped read not zero");
  property p_wr_take;
    i_ce && i_reg_wr && i_reg_addr == 8'h5e |=>
      i_reg_addr != 8'h5e || o_reg_rdata == $past(i_reg_wdata);
  endproperty
  a_wr_take: assert property (p_wr_take)
    else $error("mask write lost");
  property p_zero;
    !o_loaded |-> o_freq_khz == 12'h000 && o_vboot_mv == 13'h0000;
  endproperty
  a_zero: assert property (p_zero)
    else $error("output before load");
  property p_stays;
    o_loaded |=> o_loaded;
  endproperty
  a_stays: assert property (p_stays)
    else $error("load dropped");
  property p_load_time;
    !o_loaded |-> cnt_q < 5'h0c;
  endproperty
  a_load_time: assert property (p_load_time)
    else $error("boot load too slow");
  property p_freq_legal;
    o_freq_khz != 12'h000 && o_freq_khz != $past(i_reg_freq_khz) |->
      o_freq_khz inside {[12'h190:12'h7d0]} &&
      o_freq_khz % 12'h0c8 == 12'h000 && o_freq_khz != 12'h640;
  endproperty
  a_freq_legal: assert property (p_freq_legal)
    else $error("illegal pin frequency");
  property p_variant;
    o_loaded && i_reg_variant |=> o_vboot_mv == $past(i_reg_vboot_mv);
  endproperty
  a_variant: assert property (p_variant)
    else $error("variant used pin value");
  property p_rovp_set;
    o_rovp_mv != 9'h000 && o_rovp_mv != $past(i_reg_rovp_mv) |->
      o_rovp_mv inside {9'h096, 9'h0c8, 9'h0fa, 9'h12c};
  endproperty
  a_rovp_set: assert property (p_rovp_set)
    else $error("illegal relative margin");
  c_load: cover property ($rose(o_loaded));
  c_wr: cover property (i_reg_wr && i_reg_addr == 8'h5e);
  c_var: cover property (o_loaded && i_reg_variant);
endmodule : pscd_checker
bind pscd_decode pscd_checker u_chk (.i_clk, .i_nrst, .i_ce,
  .i_reg_variant, .i_reg_addr, .i_reg_wr, .i_reg_wdata, .o_reg_rdata,
  .i_reg_freq_khz, .i_reg_vboot_mv, .i_reg_rovp_mv, .o_loaded,
  .o_freq_khz, .o_vboot_mv, .o_rovp_mv);
`default_nettype wire

// [testbench/pscd_strap_model.sv]
// strap resistor model: chosen resistors become pin bins
`timescale 1ns/1ps
`default_nettype none
module pscd_strap_model (
  // chosen resistor per pin, 0 is a short
  input wire logic [3:0] i_mode_sel,
  input wire logic [3:0] i_vbt_sel,
  // both pins left open
  input wire logic i_float,
  // bins seen by the comparators
  output logic [3:0] o_mode_bin,
  output logic [3:0] o_boot_voltage_strap
);
  assign o_mode_bin = i_float ? 4'hf : i_mode_sel;
  assign o_boot_voltage_strap = i_float ? 4'hf : i_vbt_sel;
endmodule : pscd_strap_model
`default_nettype wire

// [testbench/tb_top.sv]
// self-checking bench for the strap decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(a,b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
  $display("FAIL t=%0t got=%0h exp=%0h", $time, a, b); end end
module tb_top;
  // clock, reset and straps
  logic i_clk = 0, i_nrst = 0, i_ce = 1, flt = 0;
  logic i_reg_variant = 0, i_scale_half = 0, i_reg_wr = 0;
  logic [3:0] msel = 0, vsel = 0, i_mode_bin, i_boot_voltage_strap;
  logic [7:0] i_reg_addr = 8'h5e, i_reg_wdata = 8'h00, o_reg_rdata;
  // host-held values, picked unlike any pin value except fovp 1500 and diode emulation 1
  logic [11:0] i_reg_freq_khz = 12'h309, o_freq_khz;
  logic i_reg_diode_emulation = 1, o_diode_emulation, o_loaded;
  logic [12:0] i_reg_vboot_mv = 13'h04d2, o_vboot_mv;
  logic [12:0] i_reg_fovp_mv = 13'h05dc, o_fovp_mv;
  logic [8:0] i_reg_rovp_mv = 9'h063, o_rovp_mv;
  int num_errors = 0, checks_done = 0, cyc = 0;
  // expected values per bin, kHz and mV
  int fq[16] = '{600, 1000, 1400, 2000, 1200, 1400, 1800, 2000,
    400, 600, 800, 1000, 400, 1800, 1200, 800};
  int v1[16] = '{400, 500, 600, 700, 800, 900, 1000, 1050,
    1100, 1200, 1250, 1350, 1500, 1650, 1800, 2500};
  int f1[16] = '{800, 1000, 1000, 1200, 1200, 1200, 1350, 1350,
    1350, 1500, 1800, 1800, 2200, 2200, 2200, 2850};
  int v2[16] = '{800, 1000, 1200, 1400, 1600, 1800, 2000, 2100,
    2200, 2400, 2500, 2700, 3000, 3300, 3600, 5000};
  int f2[16] = '{1600, 1600, 1600, 2000, 2400, 2400, 2700, 2700,
    2700, 3000, 3000, 3600, 3600, 4400, 4400, 5700};
  always #12.5 i_clk = ~i_clk;
  pscd_strap_model u_straps (.i_mode_sel(msel), .i_vbt_sel(vsel),
    .i_float(flt), .o_mode_bin(i_mode_bin),
    .o_boot_voltage_strap(i_boot_voltage_strap));
  pscd_decode u_dut (.i_clk, .i_nrst, .i_ce, .i_reg_variant,
    .i_scale_half, .i_mode_bin, .i_boot_voltage_strap, .i_reg_addr,
    .i_reg_wr, .i_reg_wdata, .o_reg_rdata, .i_reg_freq_khz,
    .i_reg_diode_emulation, .i_reg_vboot_mv, .i_reg_fovp_mv,
    .i_reg_rovp_mv, .o_loaded, .o_freq_khz, .o_diode_emulation,
    .o_vboot_mv, .o_fovp_mv, .o_rovp_mv);
  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out
  // hang guard, whole run needs well under this
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      num_errors++;
      close_out();
    end
  end
  // reset for five cycles with straps set, then wait for load
  task automatic boot(input int b, input bit s, input bit v);
    int n;
    @(negedge i_clk);
    i_nrst = 0;
    msel = 4'(b % 15);
    vsel = 4'(b % 15);
    flt = (b == 15);
    i_scale_half = s;
    i_reg_variant = v;
    repeat (5) @(negedge i_clk);
    i_nrst = 1;
    n = 0;
    while (o_loaded !== 1'b1 && n < 30)
    begin
      @(negedge i_clk);
      n++;
    end
    `CHK(o_loaded, 1'b1)
    @(negedge i_clk);
  endtask : boot
  // one register write, strobe held one cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1;
    @(negedge i_clk);
    i_reg_wr = 0;
    i_reg_addr = 8'h5e;
    @(negedge i_clk);
  endtask : wr
  task automatic chk_pins(input int b, input bit s);
    int ro;
    ro = s ? (b < 3 ? 200 : 300) : (b < 4 ? 150 : b < 10 ? 200 :
      b < 12 ? 250 : 300);
    `CHK(o_freq_khz, 12'(fq[b]))
    `CHK(o_diode_emulation, 1'(b > 3 && b < 12))
    `CHK(o_vboot_mv, 13'(s ? v2[b] : v1[b]))
    `CHK(o_fovp_mv, 13'(s ? f2[b] : f1[b]))
    `CHK(o_rovp_mv, 9'(ro))
  endtask : chk_pins
  task automatic chk_reg;
    `CHK(o_freq_khz, i_reg_freq_khz)
    `CHK(o_diode_emulation, i_reg_diode_emulation)
    `CHK(o_vboot_mv, i_reg_vboot_mv)
    `CHK(o_fovp_mv, i_reg_fovp_mv)
    `CHK(o_rovp_mv, i_reg_rovp_mv)
  endtask : chk_reg
  initial
  begin
    // every bin in both scales, short and open included
    for (int b = 0; b < 16; b++)
      for (int s = 0; s < 2; s++)
      begin
        boot(b, s[0], 0);
        chk_pins(b, s[0]);
      end
    $display("pin table done");
    // straps moved after load must be ignored; float dropped so pins move
    flt = 0;
    msel = 4'h9;
    i_scale_half = 0;
    repeat (3) @(negedge i_clk);
    chk_pins(15, 1);
    boot(2, 0, 0);
    // frequency alone to register, others stay on pins
    wr(8'h5e, 8'h10);
    `CHK(o_reg_rdata, 8'h10)
    `CHK(o_freq_khz, i_reg_freq_khz)
    `CHK(o_vboot_mv, 13'h0258)
    wr(8'h5d, 8'hff);
    `CHK(o_reg_rdata, 8'h10)
    wr(8'h5e, 8'hf8);
    chk_reg();
    // frozen clock enable drops the write
    i_ce = 0;
    wr(8'h5e, 8'h00);
    i_ce = 1;
    `CHK(o_reg_rdata, 8'hf8)
    wr(8'h5e, 8'h00);
    chk_pins(2, 0);
    $display("override done");
    // reset in mid-run clears everything
    @(negedge i_clk);
    i_nrst = 0;
    #1;
    `CHK(o_loaded, 1'b0)
    `CHK(o_freq_khz, 12'h000)
    `CHK(o_reg_rdata, 8'h00)
    i_reg_vboot_mv = 13'h0000;
    boot(9, 1, 1);
    chk_reg();
    `CHK(o_vboot_mv, 13'h0000)
    $display("variant done");
    close_out();
  end
endmodule : tb_top
`default_nettype wire
